// >>> hw/rx_filter_params.svh
// Offsets, field positions, reset values and timing counts of the filter
`ifndef RX_FILTER_PARAMS_SVH
`define RX_FILTER_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_MODE       12'h000
`define OFS_OPTION     12'h004
`define OFS_BUF_LEN    12'h008
`define OFS_RX_STATUS  12'h00c
`define OFS_SLOT_SEL   12'h010
`define OFS_SLOT_LO    12'h014
`define OFS_SLOT_HI    12'h018
`define OFS_SLOT_EN    12'h01c
`define OFS_STAT_BASE  12'h100

// ----------------------------------------------------------------------
// Receive return codes
// ----------------------------------------------------------------------
`define ST_OK          8'h00
`define ST_TRUNC       8'h04
`define ST_ALIGN       8'h10
`define ST_CRC         8'h20
`define ST_SMALL       8'h40

// ----------------------------------------------------------------------
// Option mask bits and reset values
// ----------------------------------------------------------------------
`define OPT_ALIGN_BIT  4
`define OPT_CRC_BIT    5
`define OPT_DIS_BIT    7
`define OPTION_RESET   8'h00

// ----------------------------------------------------------------------
// Address slots
// ----------------------------------------------------------------------
`define SLOT_NULL      8'h00
`define SLOT_PHYS      8'hfd
`define SLOT_UNIV      8'hfe
`define SLOT_BCAST     8'hff
`define BCAST_ADDR     48'hffff_ffff_ffff
`define DA_BYTES       17'h00006

// ----------------------------------------------------------------------
// Buffers, statistics and timing
// ----------------------------------------------------------------------
`define MIN_BUF_LEN    16'h0040
`define BUF_LEN_MASK   16'hfff8
`define STAT_TX_OK     3'h0
`define STAT_TX_ABORT  3'h1
`define STAT_TDR       3'h3
`define STAT_RX_OK     3'h4
`define STAT_RX_ALIGN  3'h5
`define STAT_RX_CRC    3'h6
`define STAT_RX_LOST   3'h7
`define CLK_PERIOD_NS  10
`define TDR_UNIT_NS    100
`define TDR_DIV        (`TDR_UNIT_NS / `CLK_PERIOD_NS)

`endif

// >>> hw/rx_filter_pkg.sv
// Types shared by the receive filter design
package rx_filter_pkg;

  typedef enum logic [1:0] {
    MODE_OFF       = 2'b00,
    MODE_PERFECT   = 2'b01,
    MODE_IMPERFECT = 2'b10,
    MODE_PROMISC   = 2'b11
  } net_mode_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_TAKE = 2'b01,
    RX_SKIP = 2'b10
  } rx_state_e;

endpackage

// >>> hw/stat_counter.sv
// Saturating statistics event counter
`timescale 1ns/1ps
`default_nettype none

module stat_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clr_i,
  input  wire logic             inc_i,
  output logic [WIDTH-1:0]      count_o
);

  wire at_max = (count_o == {WIDTH{1'b1}});

  // Clear and count in one cycle keeps the new event
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_o <= '0;
    end else if (clr_i) begin
      count_o <= {{(WIDTH-1){1'b0}}, inc_i};
    end else if (inc_i && !at_max) begin
      count_o <= count_o + 1'b1;
    end
  end

  a_count_sat: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    at_max && !clr_i |=> at_max)
    else $error("counter left its maximum");

  a_count_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clr_i && !inc_i |=> count_o == '0)
    else $error("counter not cleared");

endmodule

`default_nettype wire

// >>> hw/eth_rx_filter.sv
// Receive filter, buffer completion and statistics of the network controller
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_params.svh"

module eth_rx_filter
  import rx_filter_pkg::*;
#(
  parameter int NUM_MCAST = 252
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [47:0] station_addr_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_last_i,
  input  wire logic        rx_align_err_i,
  input  wire logic        rx_crc_err_i,
  input  wire logic        tx_start_i,
  input  wire logic        tx_coll_i,
  input  wire logic        tx_ok_i,
  input  wire logic        tx_abort_i,
  output logic             wr_en_o,
  output logic      [15:0] wr_addr_o,
  output logic      [7:0]  wr_data_o,
  output logic             done_o,
  output logic             wire_en_o
);

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  net_mode_e   mode;
  logic [7:0]  opt;
  logic [15:0] buf_len;
  logic        buf_armed;
  logic [7:0]  slot_sel;
  logic [31:0] slot_lo;
  logic        init_pend;
  logic [7:0]  rx_status;
  logic [7:0]  rx_slot;
  logic [15:0] rx_len;

  wire wr_mode  = reg_wr_i && (reg_addr_i == `OFS_MODE);
  wire wr_opt   = reg_wr_i && (reg_addr_i == `OFS_OPTION);
  wire wr_buf   = reg_wr_i && (reg_addr_i == `OFS_BUF_LEN);
  wire wr_sel   = reg_wr_i && (reg_addr_i == `OFS_SLOT_SEL);
  wire wr_lo    = reg_wr_i && (reg_addr_i == `OFS_SLOT_LO);
  wire wr_hi    = reg_wr_i && (reg_addr_i == `OFS_SLOT_HI);
  wire wr_en    = reg_wr_i && (reg_addr_i == `OFS_SLOT_EN);
  wire small_buf = wr_buf && (reg_wdata_i[15:0] < `MIN_BUF_LEN);
  wire stat_hit = (reg_addr_i[11:5] == 7'(`OFS_STAT_BASE >> 5));
  wire [2:0] stat_idx = reg_addr_i[4:2];

  // --------------------------------------------------------------------
  // Address slots
  // --------------------------------------------------------------------
  logic [47:0]  slot_addr [256];
  logic [255:0] slot_en;
  logic [255:0] exact_hit;
  logic [255:0] mc_exact;
  logic [255:0] hash_hit;
  logic [47:0]  da;
  logic [47:0]  da_eff;

  function automatic logic [5:0] hash6(input logic [47:0] a);
    logic [5:0] h;
    h = 6'h00;
    for (int k = 0; k < 8; k++) begin
      h = h ^ a[k*6 +: 6];
    end
    return h;
  endfunction

  wire [5:0] da_hash = hash6(da_eff);

  genvar gi;
  for (gi = 0; gi < 256; gi++) begin : g_slot
    localparam logic [7:0] IDX = 8'(gi);
    localparam bit IS_MC = (gi >= 1) && (gi <= NUM_MCAST);
    localparam bit CAN_HIT = IS_MC || (IDX == `SLOT_PHYS) ||
                             (IDX == `SLOT_BCAST);
    logic [47:0] addr_q;
    logic        en_q;
    wire         sel_w = (slot_sel == IDX);
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        addr_q <= (IDX == `SLOT_BCAST) ? `BCAST_ADDR : 48'h0;
        en_q   <= (IDX == `SLOT_PHYS) || (IDX == `SLOT_BCAST);
      end else if (init_pend && IDX == `SLOT_PHYS) begin
        addr_q <= station_addr_i;
      end else if (wr_hi && sel_w && IDX != `SLOT_BCAST) begin
        addr_q <= {reg_wdata_i[15:0], slot_lo};
        en_q   <= 1'b0;
      end else if (wr_en && sel_w) begin
        en_q   <= reg_wdata_i[0];
      end
    end
    assign slot_addr[gi] = addr_q;
    assign slot_en[gi]   = en_q;
    assign exact_hit[gi] = CAN_HIT && en_q && (addr_q == da_eff);
    assign mc_exact[gi]  = IS_MC && exact_hit[gi];
    assign hash_hit[gi]  = IS_MC && en_q && (hash6(addr_q) == da_hash);
  end

  logic [7:0] mc_idx;
  always_comb begin
    mc_idx = `SLOT_NULL;
    for (int k = 255; k >= 1; k--) begin
      if (mc_exact[k]) begin
        mc_idx = 8'(k);
      end
    end
  end

  // --------------------------------------------------------------------
  // Frame intake
  // --------------------------------------------------------------------
  rx_state_e   state;
  rx_state_e   next_state;
  net_mode_e   f_mode;
  logic        f_buf;
  logic [15:0] f_lim;
  logic [15:0] cnt;

  wire        idle      = (state == RX_IDLE);
  wire        frame_on  = (mode != MODE_OFF) && !opt[`OPT_DIS_BIT];
  wire        take_byte = rx_valid_i &&
                          ((state == RX_TAKE) || (idle && frame_on));
  wire [15:0] byte_idx  = idle ? 16'h0000 : cnt;
  net_mode_e  cur_mode;
  assign cur_mode = idle ? mode : f_mode;
  wire        cur_buf   = idle ? buf_armed : f_buf;
  wire [15:0] cur_lim   = idle ? (buf_len & `BUF_LEN_MASK) : f_lim;
  wire        wr_go     = take_byte && cur_buf && (byte_idx < cur_lim);
  wire        end_take  = take_byte && rx_last_i;
  wire [16:0] total     = {1'b0, byte_idx} + 17'h00001;
  wire        trunc     = total > {1'b0, cur_lim};
  wire [15:0] stored    = trunc ? cur_lim : total[15:0];
  wire        da_ok     = total >= `DA_BYTES;
  assign da_eff = (byte_idx < 16'h0006) ? {da[39:0], rx_data_i} : da;

  always_comb begin
    next_state = state;
    unique case (state)
      RX_IDLE: begin
        if (rx_valid_i && !rx_last_i) begin
          next_state = frame_on ? RX_TAKE : RX_SKIP;
        end
      end
      RX_TAKE, RX_SKIP: begin
        if (rx_valid_i && rx_last_i) begin
          next_state = RX_IDLE;
        end
      end
      default: next_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state  <= RX_IDLE;
      f_mode <= MODE_OFF;
      f_buf  <= 1'b0;
      f_lim  <= 16'h0000;
      cnt    <= 16'h0000;
      da     <= 48'h0;
    end else begin
      state <= next_state;
      if (take_byte) begin
        f_mode <= cur_mode;
        f_buf  <= cur_buf;
        f_lim  <= cur_lim;
        cnt    <= (byte_idx == 16'hffff) ? byte_idx : total[15:0];
        da     <= da_eff;
      end
    end
  end

  // --------------------------------------------------------------------
  // Destination filter
  // --------------------------------------------------------------------
  wire is_mc = da_eff[40];
  wire is_bc = (da_eff == `BCAST_ADDR);
  logic       accept;
  logic [7:0] hit_slot;

  always_comb begin
    accept   = 1'b0;
    hit_slot = `SLOT_NULL;
    if (cur_mode == MODE_PROMISC) begin
      accept   = 1'b1;
      hit_slot = `SLOT_UNIV;
    end else if (!is_mc) begin
      accept   = exact_hit[`SLOT_PHYS];
      hit_slot = `SLOT_PHYS;
    end else if (cur_mode == MODE_IMPERFECT) begin
      accept   = exact_hit[`SLOT_BCAST] || (|hash_hit);
      hit_slot = `SLOT_UNIV;
    end else if (is_bc) begin
      accept   = exact_hit[`SLOT_BCAST];
      hit_slot = `SLOT_BCAST;
    end else begin
      accept   = (|hash_hit) && (|mc_exact);
      hit_slot = mc_idx;
    end
  end

  wire crc_bad  = rx_crc_err_i;
  wire aln_bad  = rx_align_err_i;
  wire err_ok   = (!crc_bad || opt[`OPT_CRC_BIT]) &&
                  (!aln_bad || opt[`OPT_ALIGN_BIT]);
  wire wanted   = end_take && da_ok && accept && err_ok;
  wire deliver  = wanted && cur_buf;
  wire lost     = wanted && !cur_buf;
  wire [7:0] fr_status = crc_bad ? `ST_CRC   :
                         aln_bad ? `ST_ALIGN :
                         trunc   ? `ST_TRUNC : `ST_OK;

  // --------------------------------------------------------------------
  // Control registers and completion
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode      <= MODE_OFF;
      opt       <= `OPTION_RESET;
      slot_sel  <= `SLOT_NULL;
      slot_lo   <= 32'h0;
      init_pend <= 1'b1;
      buf_len   <= 16'h0000;
      buf_armed <= 1'b0;
    end else begin
      init_pend <= 1'b0;
      if (wr_mode) mode <= net_mode_e'(reg_wdata_i[1:0]);
      if (wr_opt) opt <= reg_wdata_i[7:0];
      if (wr_sel) slot_sel <= reg_wdata_i[7:0];
      if (wr_lo) slot_lo <= reg_wdata_i;
      if (wr_buf) begin
        buf_len   <= reg_wdata_i[15:0];
        buf_armed <= !small_buf;
      end else if (deliver) begin
        buf_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_o    <= 1'b0;
      rx_status <= `ST_OK;
      rx_slot   <= `SLOT_NULL;
      rx_len    <= 16'h0000;
    end else begin
      done_o <= deliver || small_buf;
      if (small_buf) begin
        rx_status <= `ST_SMALL;
        rx_slot   <= `SLOT_NULL;
        rx_len    <= 16'h0000;
      end else if (deliver) begin
        rx_status <= fr_status;
        rx_slot   <= hit_slot;
        rx_len    <= stored;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_en_o   <= 1'b0;
      wr_addr_o <= 16'h0000;
      wr_data_o <= 8'h00;
      wire_en_o <= 1'b0;
    end else begin
      wr_en_o   <= wr_go;
      wr_addr_o <= byte_idx;
      wr_data_o <= rx_data_i;
      wire_en_o <= frame_on;
    end
  end

  // --------------------------------------------------------------------
  // Statistics and reflection delay
  // --------------------------------------------------------------------
  logic [31:0] stat_val [8];
  logic [7:0]  stat_inc;
  logic [3:0]  tdr_div;
  logic        tdr_run;
  logic [15:0] tdr_cnt;
  logic [15:0] cable_reflection_delay;

  wire seen = end_take && da_ok;
  assign stat_inc = {lost, seen && crc_bad, seen && aln_bad,
                     deliver && !crc_bad && !aln_bad, 2'b00,
                     tx_abort_i, tx_ok_i};

  genvar si;
  for (si = 0; si < 8; si++) begin : g_stat
    if (si == 2 || si == 3) begin : g_none
      assign stat_val[si] = (si == 3) ? {16'h0000, cable_reflection_delay}
                                      : 32'h0;
    end else begin : g_cnt
      stat_counter #(
        .WIDTH(32)
      ) u_cnt (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .clr_i    (reg_wr_i && stat_hit && stat_idx == 3'(si)),
        .inc_i    (stat_inc[si]),
        .count_o  (stat_val[si])
      );
    end
  end

  wire tdr_tick = (tdr_div == 4'(`TDR_DIV - 1));

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdr_div <= 4'h0;
      tdr_run <= 1'b0;
      tdr_cnt <= 16'h0000;
      cable_reflection_delay <= 16'h0000;
    end else begin
      tdr_div <= (tdr_tick || tx_start_i) ? 4'h0 : tdr_div + 4'h1;
      if (tx_start_i) begin
        tdr_run <= 1'b1;
        tdr_cnt <= 16'h0000;
      end else if (tdr_run && tx_coll_i) begin
        tdr_run <= 1'b0;
        cable_reflection_delay <= tdr_cnt;
      end else if (tdr_run && tdr_tick && tdr_cnt != 16'hffff) begin
        tdr_cnt <= tdr_cnt + 16'h0001;
      end
      if (reg_wr_i && stat_hit && stat_idx == `STAT_TDR &&
          !(tdr_run && tx_coll_i)) begin
        cable_reflection_delay <= 16'h0000;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    unique case (reg_addr_i)
      `OFS_MODE:      rd_word = {30'h0, mode};
      `OFS_OPTION:    rd_word = {24'h0, opt};
      `OFS_BUF_LEN:   rd_word = {15'h0, buf_armed, buf_len};
      `OFS_RX_STATUS: rd_word = {rx_len, rx_slot, rx_status};
      `OFS_SLOT_SEL:  rd_word = {24'h0, slot_sel};
      `OFS_SLOT_LO:   rd_word = slot_addr[slot_sel][31:0];
      `OFS_SLOT_HI:   rd_word = {16'h0, slot_addr[slot_sel][47:32]};
      `OFS_SLOT_EN:   rd_word = {31'h0, slot_en[slot_sel]};
      default:        rd_word = stat_hit ? stat_val[stat_idx] : 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_word : 32'h0;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_mode_hold: assert property (!wr_mode |=> $stable(mode))
    else $error("mode changed without a write");
  a_small_buf: assert property (small_buf |=> done_o &&
    rx_status == `ST_SMALL && !buf_armed)
    else $error("short buffer not completed with 40H");
  a_trunc_len: assert property (done_o && rx_status == `ST_TRUNC
    |-> rx_len[2:0] == 3'h0 && rx_len >= `MIN_BUF_LEN)
    else $error("truncated length not a multiple of eight");
  a_promisc_slot: assert property (deliver && cur_mode == MODE_PROMISC
    |=> done_o && rx_slot == `SLOT_UNIV)
    else $error("promiscuous frame without universal slot");
  a_crc_gate: assert property (done_o && rx_status == `ST_CRC
    |-> $past(opt[`OPT_CRC_BIT]))
    else $error("check error frame delivered while not allowed");
  a_addr_clear_en: assert property (wr_hi && slot_sel != `SLOT_BCAST
    |=> !slot_en[$past(slot_sel)])
    else $error("address write kept slot enabled");
  a_off_quiet: assert property (idle && rx_valid_i && !frame_on
    ##1 (state == RX_SKIP) [*2] |-> !wr_en_o &&
    !(done_o && rx_status != `ST_SMALL))
    else $error("off net frame stored");
  a_tdr_capture: assert property (tdr_run && tx_coll_i && !tx_start_i
    |=> cable_reflection_delay == $past(tdr_cnt))
    else $error("collision delay not captured");

  c_good: cover property (done_o && rx_status == `ST_OK);
  c_trunc: cover property (done_o && rx_status == `ST_TRUNC);
  c_lost: cover property (lost);
  c_promisc: cover property (deliver && cur_mode == MODE_PROMISC);

endmodule

`default_nettype wire

// >>> test/medium_model.sv
// Wire-side model that hands received frames to the filter
`timescale 1ns/1ps
`default_nettype none
module medium_model (
  input  wire logic       mclk_i,
  output var  logic       valid_o,
  output var  logic [7:0] data_o,
  output var  logic       last_o,
  output var  logic [1:0] err_o
);
  initial begin
    valid_o = 1'b0;
    data_o = 8'h5a;
    last_o = 1'b0;
    err_o = 2'h0;
  end
  // Frame starts at the destination field, most significant byte first
  task automatic send(input logic [47:0] da, input int n,
                      input logic [1:0] er);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      valid_o <= 1'b1;
      data_o <= (i < 6) ? da[47-8*i -: 8] : i[7:0];
      last_o <= (i == n - 1);
      err_o <= (i == n - 1) ? er : 2'h0;
    end
    @(posedge mclk_i);
    valid_o <= 1'b0;
    last_o <= 1'b0;
    err_o <= 2'h0;
    data_o <= ~data_o;
  endtask
endmodule
`default_nettype wire

// >>> test/eth_rx_filter_tb.sv
// Self-checking bench for the receive filter
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_params.svh"
module eth_rx_filter_tb
  import rx_filter_pkg::*;
;
  typedef struct packed {
    logic [1:0]  mode;
    logic [7:0]  opt;
    logic [47:0] da;
    logic [15:0] flen;
    logic [1:0]  er;
    logic        dn;
    logic [31:0] st;
  } row_s;
  localparam logic [47:0] STN = 48'h0200_0000_00aa;
  logic        clk, rst, wr, rd, rx_valid, rx_last, wr_en, done, wire_en;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [7:0]  rx_data, wr_data;
  logic [15:0] wr_addr;
  logic [1:0]  rx_er;
  logic [3:0]  tx;
  logic        got_done;
  int          num_errors, n_compared, cycles;
  int          n_wr;
  logic [7:0]  wr_b0;
  logic [31:0] exp_wr;
  row_s rows[14] = '{
    '{2'h3, 8'h00, 48'h0200_0000_0001, 16'h0040, 2'h0, 1'b1, 32'h0040_fe00},
    '{2'h3, 8'h00, 48'h0200_0000_0001, 16'h0050, 2'h0, 1'b1, 32'h0040_fe04},
    '{2'h1, 8'h00, 48'hffff_ffff_ffff, 16'h0040, 2'h0, 1'b1, 32'h0040_ff00},
    '{2'h1, 8'h00, STN, 16'h0040, 2'h0, 1'b1, 32'h0040_fd00},
    '{2'h3, 8'h10, 48'h0200_0000_0001, 16'h0040, 2'h2, 1'b1, 32'h0040_fe10},
    '{2'h3, 8'h20, 48'h0200_0000_0001, 16'h0040, 2'h1, 1'b1, 32'h0040_fe20},
    '{2'h3, 8'h00, 48'h0200_0000_0001, 16'h0040, 2'h1, 1'b0, 32'h0},
    '{2'h0, 8'h00, 48'h0200_0000_0001, 16'h0040, 2'h0, 1'b0, 32'h0},
    '{2'h1, 8'h00, 48'h0100_5e00_0001, 16'h0040, 2'h0, 1'b0, 32'h0},
    '{2'h3, 8'h80, 48'h0200_0000_0001, 16'h0040, 2'h0, 1'b0, 32'h0},
    '{2'h3, 8'h30, 48'h0200_0000_0001, 16'h0040, 2'h3, 1'b1, 32'h0040_fe20},
    '{2'h2, 8'h00, 48'hffff_ffff_ffff, 16'h0040, 2'h0, 1'b1, 32'h0040_fe00},
    '{2'h1, 8'h00, 48'h0300_0000_0003, 16'h0040, 2'h0, 1'b1, 32'h0040_0100},
    '{2'h2, 8'h00, 48'h0300_0000_0003, 16'h0040, 2'h0, 1'b1, 32'h0040_fe00}};

  eth_rx_filter #(.NUM_MCAST(4)) dut (.mclk_i(clk), .sys_rst_i(rst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .station_addr_i(STN), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_last_i(rx_last), .rx_align_err_i(rx_er[1]),
    .rx_crc_err_i(rx_er[0]), .tx_start_i(tx[3]), .tx_coll_i(tx[2]),
    .tx_ok_i(tx[1]), .tx_abort_i(tx[0]), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .done_o(done),
    .wire_en_o(wire_en));
  medium_model md (.mclk_i(clk), .valid_o(rx_valid), .data_o(rx_data),
    .last_o(rx_last), .err_o(rx_er));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (done === 1'b1) got_done = 1'b1;
    if (wr_en === 1'b1) begin
      n_wr++;
      if (wr_addr == 16'h0000) wr_b0 = wr_data;
    end
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    tx <= v;
    @(posedge clk);
    tx <= 4'h0;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    rd_reg(a, got);
    chk32(got, e);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {wr, rd, addr, wdata, tx, got_done, num_errors, n_compared} = '0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk32({31'h0, wire_en}, 32'h0);
    chk_rd(`OFS_MODE, 32'h0);
    wr_reg(`OFS_SLOT_SEL, 32'h0000_00ff);
    chk_rd(`OFS_SLOT_EN, 32'h1);
    chk_rd(`OFS_SLOT_HI, 32'h0000_ffff);
    wr_reg(`OFS_SLOT_SEL, 32'h0000_0001);
    chk_rd(`OFS_SLOT_EN, 32'h0);
    wr_reg(`OFS_SLOT_EN, 32'h1);
    chk_rd(`OFS_SLOT_EN, 32'h1);
    wr_reg(`OFS_SLOT_LO, 32'h0000_0003);
    wr_reg(`OFS_SLOT_HI, 32'h0000_0300);
    chk_rd(`OFS_SLOT_EN, 32'h0);
    wr_reg(`OFS_SLOT_EN, 32'h1);
    got_done = 1'b0;
    wr_reg(`OFS_BUF_LEN, 32'h0000_0020);
    repeat (3) @(posedge clk);
    chk32({31'h0, got_done}, 32'h1);
    chk_rd(`OFS_RX_STATUS, 32'h0000_0040);
    $display("reset and slot tests done");
    foreach (rows[r]) begin
      wr_reg(`OFS_MODE, {30'h0, rows[r].mode});
      wr_reg(`OFS_OPTION, {24'h0, rows[r].opt});
      wr_reg(`OFS_BUF_LEN, 32'h0000_0043);
      got_done = 1'b0;
      n_wr = 0;
      wr_b0 = 8'h00;
      md.send(rows[r].da, int'(rows[r].flen), rows[r].er);
      repeat (4) @(posedge clk);
      chk32({31'h0, got_done}, {31'h0, rows[r].dn});
      exp_wr = (rows[r].mode != 2'h0 && !rows[r].opt[7]) ? 32'h40 : 32'h0;
      chk32(n_wr, exp_wr);
      if (rows[r].dn) begin
        chk_rd(`OFS_RX_STATUS, rows[r].st);
        chk32({24'h0, wr_b0}, {24'h0, rows[r].da[47:40]});
      end
      $display("row %0d done", r);
    end
    md.send(48'hffff_ffff_ffff, 64, 2'h0);
    repeat (4) @(posedge clk);
    chk_rd(`OFS_STAT_BASE + 12'h010, 32'd7);
    chk_rd(`OFS_STAT_BASE + 12'h014, 32'd2);
    chk_rd(`OFS_STAT_BASE + 12'h018, 32'd3);
    chk_rd(`OFS_STAT_BASE + 12'h01c, 32'd1);
    wr_reg(`OFS_STAT_BASE + 12'h010, 32'h0);
    chk_rd(`OFS_STAT_BASE + 12'h010, 32'd0);
    pulse(4'h2);
    pulse(4'h2);
    pulse(4'h1);
    pulse(4'h8);
    repeat (35) @(posedge clk);
    pulse(4'h4);
    chk_rd(`OFS_STAT_BASE, 32'd2);
    chk_rd(`OFS_STAT_BASE + 12'h004, 32'd1);
    chk_rd(`OFS_STAT_BASE + 12'h00c, 32'd3);
    wr_reg(`OFS_MODE, {30'h0, MODE_PERFECT});
    wr_reg(`OFS_OPTION, 32'h0000_0080);
    repeat (2) @(negedge clk);
    chk32({31'h0, wire_en}, 32'h0);
    wr_reg(`OFS_OPTION, 32'h0);
    repeat (2) @(negedge clk);
    chk32({31'h0, wire_en}, 32'h1);
    $display("statistics and wire tests done");
    stop_test();
  end
endmodule
`default_nettype wire
